// *** far_serial_dev.sv ***
/* Far serial device and pin wiring for port C.
   Assumes oe high while the mux drives a pin. */
`timescale 1ns/1ps
module far_serial_dev (
  input  wire [7:0] pin_out,
  input  wire [7:0] pin_oe,
  input  wire [1:0] ext_drv,
  output wire [7:0] pin_lvl
);
  // Lower pins float high on pull-ups
  assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & {ext_drv, 6'h3f});
endmodule // far_serial_dev

// *** pin_mux_chk_sva.sv ***
/* Port assertions for the upper port C pin mux.
   Bound to every mux instance; sees its ports only. */
`timescale 1ns/1ps
module pin_mux_chk #(parameter WIDTH = 8) (
  input wire pclk, presetn, psel, penable, pwrite, pready, pslverr, ser_tx_data, ser_clk_out, ser_dt_out,
  input wire ser_dt_drive, ser_rx_data, ser_clk_in, ser_mode_en, ser_mode_sync, ser_mode_master,
  input wire [11:0] paddr, input wire [31:0] pwdata, prdata,
  input wire [WIDTH-1:0] port_c_in, port_c_out, port_c_oe);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire as = ser_mode_en & ~ser_mode_sync;
  wire sy = ser_mode_en & ser_mode_sync;
  wire ms = sy & ser_mode_master;
  wire sl = sy & ~ser_mode_master;
  a_async_tx: assert property (as && $past(as) |-> port_c_oe[6] && port_c_out[6] == $past(ser_tx_data))
    else $error("tx pin");
  a_master_clk: assert property (ms && $past(ms) |-> port_c_oe[6] && port_c_out[6] == $past(ser_clk_out))
    else $error("clk pin");
  a_slave_clk: assert property (sl && $past(sl, 3) |-> !port_c_oe[6] && ser_clk_in == $past(port_c_in[6], 3))
    else $error("clk in");
  a_async_rx: assert property (as && $past(as, 3) |-> !port_c_oe[7] && ser_rx_data == $past(port_c_in[7], 3))
    else $error("rx in");
  a_sync_data: assert property (sy && $past(sy && ser_dt_drive) |-> port_c_oe[7] && port_c_out[7] == $past(ser_dt_out))
    else $error("data pin");
  a_apb_answer: assert property (psel && !penable ##1 psel && penable |=> pready)
    else $error("no ack");
  a_no_stray: assert property (pready |-> $past(psel && penable && !pready))
    else $error("stray ack");
  a_err_ack: assert property (pslverr |-> pready)
    else $error("err alone");
  c_async: cover property (as ##1 as);
  c_slave: cover property (sl && port_c_in[6]);
  c_err: cover property (pslverr);
endmodule // pin_mux_chk
bind port_c_upper_serial_pin_mux pin_mux_chk #(.WIDTH(WIDTH)) chk (.*);

// *** port_c_pin_mux_consts.vh ***
/*
 * Register offsets, reset values and mode codes for the upper port C
 * pin multiplexer. Assumes inclusion by a single design file.
 */
`ifndef PORT_C_PIN_MUX_CONSTS_VH
`define PORT_C_PIN_MUX_CONSTS_VH

`define PC_PIN_LEVEL_OFS     12'h000
`define PC_OUTPUT_LATCH_OFS  12'h004
`define PC_DIRECTION_OFS     12'h008
`define PC_SERIAL_CTRL_OFS   12'h00c

`define PC_LATCH_RST         8'h00
`define PC_DIRECTION_RST     8'hff
`define PC_SERIAL_CTRL_RST   3'h0

`define PC_SER_EN_BIT        0
`define PC_SER_SYNC_BIT      1
`define PC_SER_MASTER_BIT    2

`define PC_SHIFT_BIT         6
`define PC_DATA_BIT          7

`endif

// *** port_c_upper_serial_pin_mux.v ***
/*
 * Port C pin logic with the two upper pins shared with the serial
 * transceiver. APB slave for pin level, output latch, direction and
 * serial mode registers. Assumes pins arrive asynchronously to pclk and
 * that the transceiver's signals are synchronous to pclk.
 */
// The placing of the registers and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "port_c_pin_mux_consts.vh"

module port_c_upper_serial_pin_mux #(
  parameter WIDTH = 8
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire [WIDTH-1:0] port_c_in,
  output reg  [WIDTH-1:0] port_c_out,
  output reg  [WIDTH-1:0] port_c_oe,
  input  wire             ser_tx_data,
  input  wire             ser_clk_out,
  input  wire             ser_dt_out,
  input  wire             ser_dt_drive,
  output reg              ser_rx_data,
  output reg              ser_clk_in,
  output reg              ser_mode_en,
  output reg              ser_mode_sync,
  output reg              ser_mode_master
);

  reg  [WIDTH-1:0] sync1_r;
  reg  [WIDTH-1:0] pin_level_r;
  reg  [WIDTH-1:0] latch_r;
  reg  [WIDTH-1:0] dir_r;
  reg  [2:0]       ser_ctrl_r;
  reg              ack_r;
  reg              err_r;
  reg  [WIDTH-1:0] out_nxt;
  reg  [WIDTH-1:0] oe_nxt;
  reg  [31:0]      rdata_nxt;
  wire             ser_en;
  wire             ser_sync;
  wire             ser_master;
  wire             access;
  wire             commit;
  wire             known;

  assign ser_en     = ser_ctrl_r[`PC_SER_EN_BIT];
  assign ser_sync   = ser_ctrl_r[`PC_SER_SYNC_BIT];
  assign ser_master = ser_ctrl_r[`PC_SER_MASTER_BIT];
  // One wait state: answer one cycle into the access phase
  assign access  = psel & penable & ~ack_r;
  // Writes land at the edge that sees pready high, never earlier
  assign commit  = psel & penable & ack_r;
  assign pready  = ack_r;
  assign known   = (paddr == `PC_PIN_LEVEL_OFS) | (paddr == `PC_OUTPUT_LATCH_OFS) |
                   (paddr == `PC_DIRECTION_OFS) | (paddr == `PC_SERIAL_CTRL_OFS);
  assign pslverr = err_r;

  // Pin drive selection
  always @* begin
    out_nxt = latch_r;
    oe_nxt  = ~dir_r;
    if (ser_en && !ser_sync) begin
      out_nxt[`PC_SHIFT_BIT] = ser_tx_data;
      oe_nxt[`PC_SHIFT_BIT]  = 1'b1;
      oe_nxt[`PC_DATA_BIT]   = 1'b0;
    end else if (ser_en) begin
      if (ser_master) begin
        out_nxt[`PC_SHIFT_BIT] = ser_clk_out;
        oe_nxt[`PC_SHIFT_BIT]  = 1'b1;
      end else begin
        oe_nxt[`PC_SHIFT_BIT]  = 1'b0;
      end
      if (ser_dt_drive) begin
        out_nxt[`PC_DATA_BIT] = ser_dt_out;
        oe_nxt[`PC_DATA_BIT]  = 1'b1;
      end else begin
        // Receive relies on software leaving the direction bit at 1
        oe_nxt[`PC_DATA_BIT]  = ~dir_r[`PC_DATA_BIT];
      end
    end
  end

  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (paddr)
      `PC_PIN_LEVEL_OFS:    rdata_nxt[WIDTH-1:0] = pin_level_r;
      `PC_OUTPUT_LATCH_OFS: rdata_nxt[WIDTH-1:0] = latch_r;
      `PC_DIRECTION_OFS:    rdata_nxt[WIDTH-1:0] = dir_r;
      `PC_SERIAL_CTRL_OFS:  rdata_nxt[2:0]       = ser_ctrl_r;
      default:              rdata_nxt = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r         <= {WIDTH{1'b0}};
      pin_level_r     <= {WIDTH{1'b0}};
      latch_r         <= `PC_LATCH_RST;
      dir_r           <= `PC_DIRECTION_RST;
      ser_ctrl_r      <= `PC_SERIAL_CTRL_RST;
      ack_r           <= 1'b0;
      err_r           <= 1'b0;
      prdata          <= 32'h0000_0000;
      port_c_out      <= {WIDTH{1'b0}};
      port_c_oe       <= {WIDTH{1'b0}};
      ser_rx_data     <= 1'b1;
      ser_clk_in      <= 1'b0;
      ser_mode_en     <= 1'b0;
      ser_mode_sync   <= 1'b0;
      ser_mode_master <= 1'b0;
    end else begin
      sync1_r         <= port_c_in;
      pin_level_r     <= sync1_r;
      port_c_out      <= out_nxt;
      port_c_oe       <= oe_nxt;
      // Link clock sampled through both stages; transceiver finds its edges
      ser_clk_in      <= pin_level_r[`PC_SHIFT_BIT];
      ser_rx_data     <= pin_level_r[`PC_DATA_BIT];
      ser_mode_en     <= ser_en;
      ser_mode_sync   <= ser_sync;
      ser_mode_master <= ser_master;
      ack_r           <= access;
      err_r           <= access & ~known;
      if (access && !pwrite) begin
        prdata <= rdata_nxt;
      end
      if (commit && pwrite) begin
        case (paddr)
          // Writes to the pin level register land in the latch
          `PC_PIN_LEVEL_OFS:    latch_r    <= pwdata[WIDTH-1:0];
          `PC_OUTPUT_LATCH_OFS: latch_r    <= pwdata[WIDTH-1:0];
          `PC_DIRECTION_OFS:    dir_r      <= pwdata[WIDTH-1:0];
          `PC_SERIAL_CTRL_OFS:  ser_ctrl_r <= pwdata[2:0];
          default:              ser_ctrl_r <= ser_ctrl_r;
        endcase
      end
    end
  end

endmodule // port_c_upper_serial_pin_mux

// *** port_c_upper_serial_pin_mux_tb_top.sv ***
/* Bench for the port C pin mux: APB driver, read queue, mode sweep.
   Assumes the far device model and checker are compiled. */
`timescale 1ns/1ps
module port_c_upper_serial_pin_mux_tb_top;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, frame = 0;
  reg ser_tx_data = 0, ser_clk_out = 0, ser_dt_out = 0, ser_dt_drive = 0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0;
  reg [1:0] drv = 2'h1;
  reg [7:0] v;
  wire [31:0] prdata;
  wire pready, pslverr, ser_rx_data, ser_clk_in, ser_mode_en, ser_mode_sync, ser_mode_master;
  wire [7:0] port_c_in, port_c_out, port_c_oe;
  integer fails = 0, check_count = 0, seed = 88, i;
  reg [32:0] expq[$];
  always #5 pclk = ~pclk;
  // Link clock runs only inside a frame
  always #40 if (frame) drv[0] = ~drv[0];
  always @(posedge pclk) {ser_tx_data, ser_clk_out, ser_dt_out, ser_dt_drive} <= $random(seed);
  port_c_upper_serial_pin_mux DUT (.*);
  far_serial_dev far (.pin_out(port_c_out), .pin_oe(port_c_oe), .ext_drv(drv), .pin_lvl(port_c_in));
  task cmp(input [47:0] nm, input [32:0] e, input [32:0] s);
    begin
      check_count++;
      if (s !== e) begin
        fails++;
        $display("mismatch %0s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 0; penable <= 0;
      @(posedge pclk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] e);
    begin
      expq.push_back({a > 12'h00c, e});
      apb(0, a, 32'h0);
    end
  endtask
  always @(posedge pclk) if (pready === 1'b1 && pwrite === 1'b0) cmp("rdata", expq.pop_front(), {pslverr, prdata});
  task test_done;
    begin
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  initial begin
    #100000 fails++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(12'h004, 32'h0);
    rd(12'h008, 32'hff);
    v = $random(seed);
    apb(1, 12'h004, {$random(seed), v});
    apb(1, 12'h008, 32'h0);
    rd(12'h004, {24'h0, v});
    rd(12'h000, {24'h0, v});
    cmp("pins", {v, 8'hff}, {port_c_out, port_c_oe});
    apb(1, 12'h008, 32'hff);
    repeat (3) @(posedge pclk);
    rd(12'h000, 32'h7f);
    rd(12'hffc, 32'h0);
    $display("register tests done");
    for (i = 0; i < 3; i++) begin
      apb(1, 12'h00c, i == 0 ? 32'h1 : i == 1 ? 32'h7 : 32'h3);
      frame <= (i == 2);
      repeat (40) @(posedge pclk);
      frame <= 0;
      rd(12'h004, {24'h0, v});
    end
    $display("serial mode tests done");
    test_done;
  end
endmodule // port_c_upper_serial_pin_mux_tb_top
